/* plr_map.svh */
/*
  register offsets, field positions, reset values and timing counts
  for the power loss ride-through block; included by the design file
*/
`ifndef PLR_MAP_SVH
`define PLR_MAP_SVH
`define PLR_CTRL_OFS    8'h00
`define PLR_LEVEL_OFS   8'h04
`define PLR_TARGET_OFS  8'h08
`define PLR_RAMP_OFS    8'h0c
`define PLR_AUX_OFS     8'h10
`define PLR_STATUS_OFS  8'h14
`define PLR_CTRL_RST    32'h0000_0050
`define PLR_LEVEL_RST   32'h00fa_00be
`define PLR_TARGET_RST  32'h0032_00f0
`define PLR_RAMP_RST    32'h0003_0000
`define PLR_AUX_RST     32'h0064_000a
`define PLR_OPSEL_LSB   0
`define PLR_METHOD_LSB  2
`define PLR_AVR_BIT     4
`define PLR_ESTOP_BIT   5
`define PLR_UNIT_BIT    6
`define PLR_CLS400_BIT  7
`define PLR_MFI_LSB     8
`define PLR_HI_LSB      16
`define PLR_UV_MIN      11'd150
`define PLR_UV_MAX      11'd210
`define PLR_ESTOP_MIN   11'd150
`define PLR_ESTOP_MAX   11'd280
`define PLR_TGT_MIN     11'd150
`define PLR_TGT_MAX     11'd400
`define PLR_DET_MAX_MS  11'd2000
`define PLR_TIME_MAX    16'd60000
`define PLR_FUNC_NC     8'd56
`define PLR_FUNC_NO     8'd57
`define PLR_CLK_KHZ     10000
`define PLR_TICK_MS     1
`define PLR_UV_FAULT_MS 10
`define PLR_FINE_MS     10
`define PLR_COARSE_MS   100
`endif

/* plr_pkg.sv */
/*
  types of the power loss ride-through block
  assumes plr_map.svh supplies the numeric constants
*/
`default_nettype none
package plr_pkg;
  typedef enum logic [4:0] {
    PLR_RUN     = 5'b00001,
    PLR_ESTOP   = 5'b00010,
    PLR_BACKUP  = 5'b00100,
    PLR_REACCEL = 5'b01000,
    PLR_FAULT   = 5'b10000
  } plr_state_t;
  typedef struct packed {
    logic [15:0] freq;
    logic        enable;
    logic        uv_fault;
    logic        backup;
  } plr_drive_t;
endpackage
`default_nettype wire

/* plr_ride_through.sv */
/*
  power loss ride-through supervisor with classic wishbone registers.
  assumes bus_volts_i is a digitised dc bus sample on clk_i, the backup
  terminal is an asynchronous pin, and run_i comes from on-chip logic.
*/
`include "plr_map.svh"
`timescale 1ns/1ps
`default_nettype none
module plr_ride_through #(
  parameter int          TICK_CYC = `PLR_CLK_KHZ * `PLR_TICK_MS,
  parameter logic [15:0] FMAX     = 16'd6000
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic [31:0]            dat_o,
  output logic                   ack_o,
  input  wire logic [11:0]       bus_volts_i,
  input  wire logic              backup_term_i,
  input  wire logic              run_i,
  input  wire logic [15:0]       freq_cmd_i,
  output logic                   avr_enable_o,
  output plr_pkg::plr_drive_t    drive_o
);
  import plr_pkg::*;

  logic [31:0] ctrl_reg, level_reg, target_reg, ramp_reg, aux_reg;
  logic        ack_reg;
  logic [31:0] rdata_next;
  plr_state_t  state_reg, state_next;
  logic [2:0]  term_sync_reg;
  logic        term_reg;
  logic [13:0] tick_cnt_reg;
  logic        tick;
  logic [11:0] volts_reg, volts_prev_reg;
  logic [10:0] det_cnt_reg;
  logic [3:0]  uv_cnt_reg;
  logic [31:0] acc_reg;
  logic [15:0] freq_reg, held_reg;
  logic        fault_reg;

  // wishbone classic slave: ack one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= cyc_i & stb_i & ~ack_reg;
    end
  end
  assign ack_o = ack_reg;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // writes land on the edge the master sees ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg   <= `PLR_CTRL_RST;
      level_reg  <= `PLR_LEVEL_RST;
      target_reg <= `PLR_TARGET_RST;
      ramp_reg   <= `PLR_RAMP_RST;
      aux_reg    <= `PLR_AUX_RST;
    end else if (ack_reg && we_i) begin
      case (adr_i)
        `PLR_CTRL_OFS:   ctrl_reg   <= merge(ctrl_reg, dat_i, sel_i);
        `PLR_LEVEL_OFS:  level_reg  <= merge(level_reg, dat_i, sel_i);
        `PLR_TARGET_OFS: target_reg <= merge(target_reg, dat_i, sel_i);
        `PLR_RAMP_OFS:   ramp_reg   <= merge(ramp_reg, dat_i, sel_i);
        `PLR_AUX_OFS:    aux_reg    <= merge(aux_reg, dat_i, sel_i);
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    case (adr_i)
      `PLR_CTRL_OFS:   rdata_next = ctrl_reg;
      `PLR_LEVEL_OFS:  rdata_next = level_reg;
      `PLR_TARGET_OFS: rdata_next = target_reg;
      `PLR_RAMP_OFS:   rdata_next = ramp_reg;
      `PLR_AUX_OFS:    rdata_next = aux_reg;
      `PLR_STATUS_OFS: rdata_next = {freq_reg, 6'h00, term_reg,
                                     fault_reg, 3'h0, state_reg};
      default:         rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !ack_reg) begin
      dat_o <= rdata_next;
    end
  end

  // configuration fields
  logic [1:0]  opsel, method;
  logic        estop_en, unit_fine, cls400;
  logic [7:0]  mfi_func;
  assign opsel     = ctrl_reg[`PLR_OPSEL_LSB +: 2];
  assign method    = ctrl_reg[`PLR_METHOD_LSB +: 2];
  assign estop_en  = ctrl_reg[`PLR_ESTOP_BIT];
  assign unit_fine = ~ctrl_reg[`PLR_UNIT_BIT];
  assign cls400    = ctrl_reg[`PLR_CLS400_BIT];
  assign mfi_func  = ctrl_reg[`PLR_MFI_LSB +: 8];
  assign avr_enable_o = ctrl_reg[`PLR_AVR_BIT];

  function automatic logic [10:0] clamp(input logic [10:0] v,
                                        input logic [10:0] lo,
                                        input logic [10:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // settings outside their range are clamped on use, not on write
  logic [10:0] uv_lvl, estop_lvl, tgt_lvl, det_ms;
  logic [3:0]  sh;
  assign sh        = {3'b000, cls400};
  assign uv_lvl    = clamp(level_reg[10:0], `PLR_UV_MIN << sh,
                           `PLR_UV_MAX << sh);
  assign estop_lvl = clamp(level_reg[`PLR_HI_LSB +: 11],
                           `PLR_ESTOP_MIN << sh, `PLR_ESTOP_MAX << sh);
  assign tgt_lvl   = clamp(target_reg[10:0], `PLR_TGT_MIN << sh,
                           `PLR_TGT_MAX << sh);
  assign det_ms    = clamp(target_reg[`PLR_HI_LSB +: 11], 11'd0,
                           `PLR_DET_MAX_MS);

  // one unit is 0.01 s or 0.1 s of ticks; both cap at 60000 units
  logic [6:0]  unit_ticks;
  assign unit_ticks = unit_fine ? 7'(`PLR_FINE_MS / `PLR_TICK_MS)
                                : 7'(`PLR_COARSE_MS / `PLR_TICK_MS);
  function automatic logic [15:0] tcap(input logic [15:0] t);
    return (t > `PLR_TIME_MAX) ? `PLR_TIME_MAX : t;
  endfunction

  // control tick divider
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 14'h0000;
    end else if (tick) begin
      tick_cnt_reg <= 14'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 14'h0001;
    end
  end
  assign tick = (tick_cnt_reg == 14'(TICK_CYC - 1));

  // terminal pin: three flops, a change counts when the last two agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      term_sync_reg <= 3'h0;
      term_reg      <= 1'b0;
    end else begin
      term_sync_reg <= {term_sync_reg[1:0], backup_term_i};
      if (term_sync_reg[1] == term_sync_reg[2]) begin
        term_reg <= term_sync_reg[2];
      end
    end
  end

  logic assigned, cmd_act;
  assign assigned = (mfi_func == `PLR_FUNC_NC) ||
                    (mfi_func == `PLR_FUNC_NO);
  assign cmd_act  = assigned && ((mfi_func == `PLR_FUNC_NC) ? ~term_reg
                                                          : term_reg);

  // bus sampled once per tick so all compares see one value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      volts_reg      <= 12'h000;
      volts_prev_reg <= 12'h000;
    end else if (tick) begin
      volts_reg      <= bus_volts_i;
      volts_prev_reg <= volts_reg;
    end
  end

  logic below_uv, backup_en, start, estop_go, det_done, fault_go, rising;
  assign below_uv  = volts_reg < {1'b0, uv_lvl};
  assign backup_en = opsel[1] | cmd_act;
  assign start     = run_i & backup_en & (below_uv | cmd_act);
  assign estop_go  = run_i & estop_en & (estop_lvl > uv_lvl) &
                     (volts_reg < {1'b0, estop_lvl}) & ~below_uv;
  assign det_done  = det_cnt_reg >= det_ms;
  assign fault_go  = (opsel == 2'd0) &&
                     (uv_cnt_reg >= 4'(`PLR_UV_FAULT_MS / `PLR_TICK_MS));
  assign rising    = volts_reg > volts_prev_reg;

  // detection timer counts ticks while backing up
  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg != PLR_BACKUP) begin
      det_cnt_reg <= 11'h000;
    end else if (tick && !det_done) begin
      det_cnt_reg <= det_cnt_reg + 11'h001;
    end
  end

  // undervoltage persistence for the disabled mode
  always_ff @(posedge clk_i) begin
    if (rst_i || !below_uv || state_reg == PLR_BACKUP) begin
      uv_cnt_reg <= 4'h0;
    end else if (tick && !fault_go) begin
      uv_cnt_reg <= uv_cnt_reg + 4'h1;
    end
  end

  // sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PLR_RUN: begin
        if (fault_go) begin
          state_next = PLR_FAULT;
        end else if (start) begin
          state_next = PLR_BACKUP;
        end else if (estop_go) begin
          state_next = PLR_ESTOP;
        end
      end
      PLR_ESTOP: begin
        if (!run_i) begin
          state_next = PLR_RUN;
        end else if (fault_go) begin
          state_next = PLR_FAULT;
        end else if (start) begin
          state_next = PLR_BACKUP;
        end else if (volts_reg >= {1'b0, estop_lvl}) begin
          state_next = PLR_REACCEL;
        end
      end
      PLR_BACKUP: begin
        if (!run_i) begin
          state_next = PLR_RUN;
        end else if (det_done && (assigned ? !cmd_act
                     : volts_reg > {1'b0, tgt_lvl})) begin
          state_next = PLR_REACCEL;
        end
      end
      PLR_REACCEL: begin
        if (!run_i || freq_reg == held_reg) begin
          state_next = PLR_RUN;
        end else if (start) begin
          state_next = PLR_BACKUP;
        end
      end
      PLR_FAULT: begin
        if (!run_i) begin
          state_next = PLR_RUN;
        end
      end
      default: state_next = PLR_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= PLR_RUN;
      fault_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      fault_reg <= (state_next == PLR_FAULT);
    end
  end

  // ramp slope: units of time times ticks per unit, and hold request
  logic [15:0] t_units;
  logic [23:0] den;
  logic        hold;
  always_comb begin
    t_units = 16'h0000;
    hold    = 1'b0;
    case (state_reg)
      PLR_ESTOP:   t_units = tcap(aux_reg[15:0]);
      PLR_REACCEL: t_units = (ramp_reg[31:16] == 16'h0000)
                           ? tcap(aux_reg[31:16])
                           : tcap(ramp_reg[31:16]);
      PLR_BACKUP: begin
        t_units = tcap(ramp_reg[15:0]);
        case (method)
          2'd0: hold = !below_uv || volts_reg >= {1'b0, tgt_lvl};
          2'd1: hold = 1'b0;
          default: hold = rising;
        endcase
        if (method == 2'd0 && below_uv) begin
          t_units = t_units >> 1;
        end
      end
      default: ;
    endcase
    // widen before the product: 60000 units of 100 ticks needs 23 bits
    den = 24'(t_units) * 24'(unit_ticks);
  end

  // frequency ramp: each tick adds fmax, each full den moves one step,
  // so the whole 0..fmax swing takes t_units of time
  logic ramping, up, at_goal;
  assign ramping = state_reg inside {PLR_ESTOP, PLR_BACKUP, PLR_REACCEL};
  assign up      = (state_reg == PLR_REACCEL);
  assign at_goal = up ? (freq_reg >= held_reg) : (freq_reg == 16'h0000);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_reg <= 16'h0000;
      acc_reg  <= 32'h0000_0000;
    end else if (state_reg == PLR_RUN || state_reg == PLR_FAULT) begin
      freq_reg <= (run_i && state_reg == PLR_RUN) ? freq_cmd_i : 16'h0000;
      acc_reg  <= 32'h0000_0000;
    end else if (ramping && !hold && !at_goal) begin
      if (den == 24'h000000) begin
        freq_reg <= up ? held_reg : 16'h0000; // zero time jumps
      end else if (tick) begin
        acc_reg <= acc_reg + {16'h0000, FMAX};
      end else if (acc_reg >= {8'h00, den}) begin
        acc_reg  <= acc_reg - {8'h00, den};
        freq_reg <= up ? freq_reg + 16'h0001 : freq_reg - 16'h0001;
      end
    end
  end

  // frequency before the loss is remembered while running normally
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held_reg <= 16'h0000;
    end else if (state_reg == PLR_RUN && run_i) begin
      held_reg <= freq_cmd_i;
    end
  end

  // outputs are all registered state; fault coasts the motor
  assign drive_o = '{freq:     freq_reg,
                     enable:   ~fault_reg,
                     uv_fault: fault_reg,
                     backup:   state_reg == PLR_BACKUP};

  property p_start;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == PLR_RUN && start && !fault_go) |=> state_reg == PLR_BACKUP;
  endproperty
  a_start: assert property (p_start)
    else $error("backup did not start");

  property p_det_min;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == PLR_BACKUP && run_i && det_cnt_reg < det_ms)
      |=> state_reg == PLR_BACKUP;
  endproperty
  a_det_min: assert property (p_det_min)
    else $error("backup left before detection time");

  property p_fault_delay;
    @(posedge clk_i) disable iff (rst_i)
    $rose(fault_reg) |-> $past(uv_cnt_reg) >= 4'd10 && opsel == 2'd0;
  endproperty
  a_fault_delay: assert property (p_fault_delay)
    else $error("undervoltage fault raised too early");

  property p_coast;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == PLR_FAULT) |=> freq_reg == 16'h0000 || !run_i;
  endproperty
  a_coast: assert property (p_coast)
    else $error("output not stopped in fault");

  property p_reaccel_cap;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == PLR_REACCEL && freq_reg <= held_reg)
      |=> freq_reg <= $past(held_reg);
  endproperty
  a_reaccel_cap: assert property (p_reaccel_cap)
    else $error("re-acceleration overshot held frequency");

  property p_m2_hold;
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == PLR_BACKUP && method == 2'd2 && rising && !tick)
      |=> freq_reg == $past(freq_reg);
  endproperty
  a_m2_hold: assert property (p_m2_hold)
    else $error("frequency moved while bus rose");

  property p_estop_en;
    @(posedge clk_i) disable iff (rst_i)
    $rose(state_reg == PLR_ESTOP) |-> $past(estop_en) && $past(run_i);
  endproperty
  a_estop_en: assert property (p_estop_en)
    else $error("emergency decel without enable");

  property p_nc_cmd;
    @(posedge clk_i) disable iff (rst_i)
    (mfi_func == `PLR_FUNC_NC && !backup_term_i)[*5] |-> cmd_act;
  endproperty
  a_nc_cmd: assert property (p_nc_cmd)
    else $error("closed-low command not seen");

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("wishbone ack timing wrong");
endmodule
`default_nettype wire

/* plr_far_side.sv */
/*
  far side of the ride-through block: dc bus sense, command terminal,
  run command and frequency command.
  assumes the bench steers it by set inputs on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module plr_far_side (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] volts_set_i,
  input  wire logic        slow_i,
  input  wire logic        term_set_i,
  input  wire logic        run_set_i,
  input  wire logic [15:0] freq_set_i,
  output logic      [11:0] bus_volts_o,
  output logic             backup_term_o,
  output logic             run_o,
  output logic      [15:0] freq_cmd_o
);
  // bus slews 4 V a cycle when slow, as a real capacitor bank would
  always_ff @(posedge clk_i) begin
    if (rst_i || !slow_i)
      bus_volts_o <= volts_set_i;
    else if (bus_volts_o + 12'h004 < volts_set_i)
      bus_volts_o <= bus_volts_o + 12'h004;
    else if (bus_volts_o > volts_set_i + 12'h004)
      bus_volts_o <= bus_volts_o - 12'h004;
    else
      bus_volts_o <= volts_set_i;
  end
  // run stays asserted through a loss unless the bench drops it
  always_ff @(posedge clk_i) begin
    run_o         <= run_set_i;
    backup_term_o <= term_set_i;
    freq_cmd_o    <= freq_set_i;
  end
endmodule
`default_nettype wire

/* tb_plr_ride_through.sv */
/*
  self-checking bench for the ride-through block: reads go through a
  queue of expected values checked when ack appears.
  assumes the design, its package and the far side model are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_plr_ride_through;
  import plr_pkg::*;
  localparam int TICK  = 20;
  localparam int LIMIT = 60000;
  localparam logic [7:0] ST = 8'h14;
  logic        clk_i, rst_i, cyc, stb, we, ack, avr, term, run;
  logic        v_slow, t_set, r_set;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat;
  logic [11:0] volts, v_set;
  logic [15:0] fcmd, f_set, rnd;
  plr_drive_t  drive;
  int          fails, samples_checked, cyc_cnt;
  logic [31:0] exp_q[$], mask_q[$];

  plr_ride_through #(.TICK_CYC(TICK)) i_plr_ride_through (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .bus_volts_i(volts), .backup_term_i(term), .run_i(run),
    .freq_cmd_i(fcmd), .avr_enable_o(avr), .drive_o(drive));
  plr_far_side i_plr_far_side (
    .clk_i(clk_i), .rst_i(rst_i), .volts_set_i(v_set), .slow_i(v_slow),
    .term_set_i(t_set), .run_set_i(r_set), .freq_set_i(f_set),
    .bus_volts_o(volts), .backup_term_o(term), .run_o(run),
    .freq_cmd_o(fcmd));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] e);
    samples_checked++;
    if (seen !== e) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, e);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    exp_q.push_back(e);
    mask_q.push_back(m);
    wb(a, 1'b0, 32'h0);
  endtask
  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge clk_i);
  endtask
  // ramp time is bounded by the short accel times set below
  task automatic wait_freq(input logic [15:0] e);
    for (int n = 0; n < 20000 && drive.freq !== e; n++) @(posedge clk_i);
  endtask

  // clock, and a cycle ceiling so a hang still reaches the verdict
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == LIMIT) begin
      fails++;
      finish_test();
    end
  end
  // read data is compared against the oldest note when ack shows
  always @(posedge clk_i)
    if (ack === 1'b1 && we === 1'b0)
      check(rdat & mask_q.pop_front(), exp_q.pop_front());

  initial begin
    clk_i = 0; rst_i = 1; cyc = 0; stb = 0; we = 0; adr = 8'h00;
    wdat = 32'h0; v_set = 12'h12c; v_slow = 0; t_set = 0; r_set = 1;
    rnd = 16'h868a; f_set = 16'h0400 + (rnd & 16'h0fff);
    fails = 0; samples_checked = 0; cyc_cnt = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'hffffffff, 32'h0000_0050);
    rd(8'h04, 32'hffffffff, 32'h00fa_00be);
    rd(8'h08, 32'hffffffff, 32'h0032_00f0);
    rd(8'h0c, 32'hffffffff, 32'h0003_0000);
    rd(8'h10, 32'hffffffff, 32'h0064_000a);
    rd(8'h18, 32'hffffffff, 32'h0);
    check({31'h0, avr}, 32'h1);
    wb(8'h00, 1'b1, 32'h0000_0040);
    repeat (2) @(posedge clk_i);
    check({31'h0, avr}, 32'h0);
    rnd = lfsr(rnd);
    wb(8'h0c, 1'b1, {16'h0003, rnd});
    rd(8'h0c, 32'hffffffff, {16'h0003, rnd});
    wb(8'h0c, 1'b1, 32'h0000_0064);
    wb(8'h10, 1'b1, 32'h0001_000a);
    wb(8'h08, 1'b1, 32'h000a_00f0);
    wb(8'h00, 1'b1, 32'h0000_0050);
    // disabled mode: fault only after ten ticks under threshold
    v_set <= 12'h0b4;
    ticks(6);
    rd(ST, 32'h0000_0100, 32'h0);
    ticks(8);
    rd(ST, 32'h0000_011f, 32'h0000_0110);
    check({drive.freq, 13'h0, drive.enable, drive.uv_fault, drive.backup},
          32'h0000_0002);
    v_set <= 12'h12c; r_set <= 1'b0;
    ticks(2);
    rd(ST, 32'hffff_0100, 32'h0);
    check({drive.freq, 13'h0, drive.enable, drive.uv_fault, drive.backup},
          32'h0000_0004);
    r_set <= 1'b1;
    // each method: minimum backup time, then target decides the end
    for (int m = 0; m < 3; m++) begin
      rnd = lfsr(rnd); f_set <= 16'h0400 + (rnd & 16'h0fff);
      // the middle method runs on the fine time unit, the others coarse
      wb(8'h00, 1'b1, (m == 1 ? 32'h0000_0012 : 32'h0000_0052) | (m << 2));
      ticks(2);
      wait_freq(f_set);
      v_set <= 12'h0b4;
      ticks(2);
      rd(ST, 32'h1f, 32'h4);
      check({31'h0, drive.backup}, 32'h1);
      v_set <= 12'h12c;
      ticks(3);
      rd(ST, 32'h1f, 32'h4);
      v_set <= 12'h0dc;
      ticks(12);
      rd(ST, 32'h1f, 32'h4);
      v_set <= 12'h12c;
      ticks(3);
      rd(ST, 32'h04, 32'h0);
      wait_freq(f_set);
      rd(ST, 32'hffff_001f, {f_set, 16'h0001});
    end
    // terminal command, both contact senses
    for (int c = 56; c < 58; c++) begin
      t_set <= (c == 56);
      wb(8'h00, 1'b1, {16'h0, c[7:0], 8'h50});
      ticks(2);
      t_set <= (c == 57);
      ticks(1);
      rd(ST, 32'h1f, 32'h4);
      ticks(14);
      rd(ST, 32'h1f, 32'h4);
      t_set <= (c == 56);
      ticks(2);
      rd(ST, 32'h04, 32'h0);
      wait_freq(f_set);
    end
    // emergency ramp gated by its enable, slow bus sag
    v_slow <= 1'b1; v_set <= 12'h0dc;
    wb(8'h00, 1'b1, 32'h0000_0052);
    ticks(2);
    rd(ST, 32'h1f, 32'h1);
    wb(8'h00, 1'b1, 32'h0000_0072);
    ticks(2);
    rd(ST, 32'h1f, 32'h2);
    v_set <= 12'h0b4;
    ticks(2);
    rd(ST, 32'h1f, 32'h4);
    v_set <= 12'h12c;
    wb(8'h00, 1'b1, 32'h0000_0052);
    ticks(16);
    wait_freq(f_set);
    // 400 V class doubles the threshold range: 190 V clamps up to 300 V, so 280 V now counts as a loss
    v_slow <= 1'b0; v_set <= 12'h118;
    ticks(2);
    rd(ST, 32'h1f, 32'h1);
    wb(8'h00, 1'b1, 32'h0000_00d2);
    ticks(2);
    rd(ST, 32'h1f, 32'h4);
    finish_test();
  end
endmodule
`default_nettype wire
